// *** verilog/uep_endpoint_ctrl.sv ***
// Endpoint control registers: IN transfer size, DMA address, FIFO space, OUT endpoint 0 control and events.
// Assumes an Avalon-MM master on the register side and a protocol engine driving core event pulses.
//
// What this block does
// - Core owns size register while endpoint enabled.
// - Packets-per-frame field, isochronous IN only.
// - Packet count decrements per packet from FIFO.
// - Byte count decrements per packet into FIFO.
// - DMA address increments by four on each bus beat while IN is enabled.
// - Over three setups overwrite stored setup data.
// - FIFO free words, resets to full size.
// - OUT0 disable bit always reads zero.
// - Snoop mode skips OUT packet checks.
// - OUT0 endpoint kind fixed at control.
// - OUT0 active bit always reads one.
// - OUT0 packet size mirrors IN0, 64B zero.
// - Clearing endpoint event clears summary bits.
// - Done flag needs bus and USB finished.
// - Enable cleared before done, disabled, setup events.
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "uep_map.svh"
`default_nettype none
module uep_endpoint_ctrl
  import uep_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [19:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire uep_core_s coreEvt,
  input wire logic [15:0] fifoWordsUsed,
  output logic snoopMode,
  output logic outNak,
  output logic inEnabled,
  output logic [31:0] endpointMemoryAddress,
  output logic setupOverwrite,
  output logic irq
);
  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  uep_tsiz_s tsiz, next_tsiz;
  uep_state_e state, next_state;
  logic [31:0] endpoint_memory_address, next_endpoint_memory_address;
  logic inEna, next_inEna;
  logic inDis, next_inDis;
  logic [6:0] inEvt, next_inEvt;
  logic out0Ena, next_out0Ena;
  logic out0Nak, next_out0Nak;
  logic out0Stall, next_out0Stall;
  logic out0Snoop, next_out0Snoop;
  logic [6:0] out0Evt, next_out0Evt;
  logic [1:0] setupCnt, next_setupCnt;
  logic [1:0] in0Mps, next_in0Mps;
  logic [1:0] irqMask, next_irqMask;
  logic [15:0] fifoFree, next_fifoFree;
  logic [31:0] rdData, next_rdData;
  logic ack, next_ack;
  logic [1:0] resp, next_resp;
  logic [31:0] ctlView, tsizView, allEvt, globEvt;
  logic access;

  assign access = (avs_read | avs_write) & ~ack;
  // Reads stall one cycle so read data comes from a flop.
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign avs_readdata = rdData;
  assign avs_response = resp;
  assign snoopMode = out0Snoop;
  assign outNak = out0Nak;
  assign inEnabled = inEna;
  assign endpointMemoryAddress = endpoint_memory_address;

  // ------------------------------------------------------------
  // Summary views
  // ------------------------------------------------------------
  always_comb begin
    ctlView = 32'h0000_0000;
    ctlView[`UEP_BIT_ENABLE] = out0Ena;
    ctlView[`UEP_BIT_DISABLE] = 1'b0;
    ctlView[`UEP_BIT_STALL] = out0Stall;
    ctlView[`UEP_BIT_SNOOP] = out0Snoop;
    ctlView[19:18] = `UEP_KIND_CONTROL;
    ctlView[`UEP_BIT_NAKSTS] = out0Nak;
    ctlView[`UEP_BIT_ACTIVE] = 1'b1;
    ctlView[1:0] = in0Mps;
    tsizView = {1'b0, tsiz};
    allEvt = 32'h0000_0000;
    allEvt[0] = |inEvt;
    allEvt[`UEP_ALL_OUT0] = |out0Evt;
    globEvt = 32'h0000_0000;
    globEvt[`UEP_GLOB_IN] = allEvt[0];
    globEvt[`UEP_GLOB_OUT] = allEvt[`UEP_ALL_OUT0];
  end
  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    next_tsiz = tsiz;
    next_state = state;
    next_endpoint_memory_address = endpoint_memory_address;
    next_inEna = inEna;
    next_inDis = inDis;
    next_inEvt = inEvt;
    next_out0Ena = out0Ena;
    next_out0Nak = out0Nak;
    next_out0Stall = out0Stall;
    next_out0Snoop = out0Snoop;
    next_out0Evt = out0Evt;
    next_setupCnt = setupCnt;
    next_in0Mps = in0Mps;
    next_irqMask = irqMask;
    next_fifoFree = 16'(`UEP_FIFO_WORDS - fifoWordsUsed);
    next_rdData = rdData;
    next_ack = 1'b0;
    next_resp = 2'b00;
    setupOverwrite = 1'b0;
    // Software side: clears and writes come first so core events below win.
    if (access) begin
      next_ack = 1'b1;
      if (avs_read) begin
        if (avs_address == `UEP_OFF_IN_TSIZ) begin
          next_rdData = tsizView;
        end else if (avs_address == `UEP_OFF_IN_DMA) begin
          next_rdData = endpoint_memory_address;
        end else if (avs_address == `UEP_OFF_IN_FIFO) begin
          next_rdData = {16'h0000, fifoFree};
        end else if (avs_address == `UEP_OFF_OUT0_CTL) begin
          next_rdData = ctlView;
        end else if (avs_address == `UEP_OFF_OUT0_EVT) begin
          next_rdData = {25'h0, out0Evt};
        end else if (avs_address == `UEP_OFF_IN_CTL) begin
          next_rdData = {inEna, inDis, 30'h0};
        end else if (avs_address == `UEP_OFF_IN_EVT) begin
          next_rdData = {25'h0, inEvt};
        end else if (avs_address == `UEP_OFF_ALL_EVT) begin
          next_rdData = allEvt;
        end else if (avs_address == `UEP_OFF_GLOB_EVT) begin
          next_rdData = globEvt;
          // Reading the global status clears the endpoint bits behind it.
          next_inEvt = 7'h00;
          next_out0Evt = 7'h00;
        end else if (avs_address == `UEP_OFF_IRQ_MASK) begin
          next_rdData = {30'h0, irqMask};
        end else if (avs_address == `UEP_OFF_IN0_MPS) begin
          next_rdData = {30'h0, in0Mps};
        end else begin
          next_rdData = 32'h0000_0000;
          next_resp = 2'b10;
        end
      end else if (avs_byteenable == 4'hF) begin
        if (avs_address == `UEP_OFF_IN_TSIZ) begin
          if (!inEna) begin
            next_tsiz = avs_writedata[30:0];
          end
        end else if (avs_address == `UEP_OFF_IN_DMA) begin
          if (!inEna) begin
            next_endpoint_memory_address = {avs_writedata[31:2], 2'b00};
          end
        end else if (avs_address == `UEP_OFF_IN_CTL) begin
          if (avs_writedata[`UEP_BIT_ENABLE]) begin
            next_inEna = 1'b1;
            next_state = RUN;
          end
          if (avs_writedata[`UEP_BIT_DISABLE] && inEna) begin
            next_inDis = 1'b1;
          end
        end else if (avs_address == `UEP_OFF_OUT0_CTL) begin
          if (avs_writedata[`UEP_BIT_ENABLE]) begin
            next_out0Ena = 1'b1;
          end
          if (avs_writedata[`UEP_BIT_STALL]) begin
            next_out0Stall = 1'b1;
          end
          if (avs_writedata[`UEP_BIT_SNAK]) begin
            next_out0Nak = 1'b1;
          end else if (avs_writedata[`UEP_BIT_CNAK]) begin
            next_out0Nak = 1'b0;
          end
          next_out0Snoop = avs_writedata[`UEP_BIT_SNOOP];
        end else if (avs_address == `UEP_OFF_OUT0_EVT) begin
          next_out0Evt = out0Evt & ~avs_writedata[6:0];
        end else if (avs_address == `UEP_OFF_IN_EVT) begin
          next_inEvt = inEvt & ~avs_writedata[6:0];
        end else if (avs_address == `UEP_OFF_IRQ_MASK) begin
          next_irqMask = avs_writedata[1:0];
        end else if (avs_address == `UEP_OFF_IN0_MPS) begin
          next_in0Mps = avs_writedata[1:0];
        end else begin
          next_resp = 2'b10;
        end
      end
    end
    // IN transfer engine.
    if (inEna) begin
      if (coreEvt.busBeat) begin
        next_endpoint_memory_address = endpoint_memory_address + 32'h0000_0004;
      end
      if (coreEvt.pktToFifo) begin
        if (coreEvt.pktBytes >= tsiz.byteCount) begin
          next_tsiz.byteCount = 19'h00000;
        end else begin
          next_tsiz.byteCount = tsiz.byteCount - coreEvt.pktBytes;
        end
      end
      if (coreEvt.pktFromFifo && tsiz.pktCount != 10'h000) begin
        next_tsiz.pktCount = tsiz.pktCount - 10'h001;
      end
    end
    case (state)
      IDLE: begin
      end
      RUN: begin
        // Both counts at zero means bus and USB are finished.
        if (inDis || (tsiz.pktCount == 10'h000 && tsiz.byteCount == 19'h00000)) begin
          next_inEna = 1'b0;
          next_state = FINISH;
        end
      end
      FINISH: begin
        // The enable dropped a cycle earlier, so the event follows it.
        if (inDis) begin
          next_inEvt[`UEP_EV_DISABLED] = 1'b1;
          next_inDis = 1'b0;
        end else begin
          next_inEvt[`UEP_EV_DONE] = 1'b1;
        end
        next_state = IDLE;
      end
      default: begin
        next_state = IDLE;
      end
    endcase
    // OUT endpoint 0 setup handling.
    if (coreEvt.setupRcvd && out0Ena) begin
      next_out0Stall = 1'b0;
      next_out0Nak = 1'b1;
      if (setupCnt == `UEP_MAX_SETUP) begin
        setupOverwrite = 1'b1;
        next_out0Evt[`UEP_EV_B2B] = 1'b1;
      end else begin
        next_setupCnt = setupCnt + 2'h1;
      end
    end
    if (coreEvt.outPktRcvd && out0Ena) begin
      // Snoop mode accepts a bad packet; the setup count stays so setup-done can follow.
      if (!coreEvt.outPktBad || out0Snoop) begin
        next_out0Ena = 1'b0;
      end
    end
    if (!out0Ena && setupCnt != 2'h0) begin
      next_out0Evt[`UEP_EV_SETUP] = 1'b1;
      next_setupCnt = 2'h0;
    end
  end

  // ------------------------------------------------------------
  // Registering
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tsiz <= '0;
      state <= IDLE;
      endpoint_memory_address <= 32'h0000_0000;
      inEna <= 1'b0;
      inDis <= 1'b0;
      inEvt <= 7'h00;
      out0Ena <= 1'b0;
      out0Nak <= 1'b0;
      out0Stall <= 1'b0;
      out0Snoop <= 1'b0;
      out0Evt <= 7'h00;
      setupCnt <= 2'h0;
      in0Mps <= 2'h0;
      irqMask <= 2'h0;
      fifoFree <= `UEP_FIFO_WORDS;
      rdData <= 32'h0000_0000;
      ack <= 1'b0;
      resp <= 2'b00;
      irq <= 1'b0;
    end else if (clkEn) begin
      tsiz <= next_tsiz;
      state <= next_state;
      endpoint_memory_address <= next_endpoint_memory_address;
      inEna <= next_inEna;
      inDis <= next_inDis;
      inEvt <= next_inEvt;
      out0Ena <= next_out0Ena;
      out0Nak <= next_out0Nak;
      out0Stall <= next_out0Stall;
      out0Snoop <= next_out0Snoop;
      out0Evt <= next_out0Evt;
      setupCnt <= next_setupCnt;
      in0Mps <= next_in0Mps;
      irqMask <= next_irqMask;
      fifoFree <= next_fifoFree;
      rdData <= next_rdData;
      ack <= next_ack;
      resp <= next_resp;
      irq <= (|next_inEvt & irqMask[0]) | (|next_out0Evt & irqMask[1]);
    end
  end
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_doneAfterEnable;
    @(posedge core_clk) disable iff (rst)
    $rose(inEvt[`UEP_EV_DONE]) |-> !inEna && !$past(inEna);
  endproperty
  a_doneAfterEnable: assert property (p_doneAfterEnable) else $error("done raised with enable set");
  property p_doneNeedsZero;
    @(posedge core_clk) disable iff (rst)
    $rose(inEvt[`UEP_EV_DONE]) && !$past(inDis, 2)
      |-> $past(tsiz.pktCount, 2) == 10'h000 && $past(tsiz.byteCount, 2) == 19'h00000;
  endproperty
  a_doneNeedsZero: assert property (p_doneNeedsZero) else $error("done without zero counts");
  property p_pktDec;
    @(posedge core_clk) disable iff (rst)
    clkEn && inEna && coreEvt.pktFromFifo && tsiz.pktCount != 10'h0 && !access
      |=> tsiz.pktCount == $past(tsiz.pktCount) - 10'h001;
  endproperty
  a_pktDec: assert property (p_pktDec) else $error("packet count not decremented");
  property p_dmaInc;
    @(posedge core_clk) disable iff (rst)
    clkEn && inEna && coreEvt.busBeat |=> endpoint_memory_address == $past(endpoint_memory_address) + 32'h0000_0004;
  endproperty
  a_dmaInc: assert property (p_dmaInc) else $error("address not advanced");
  property p_disZero;
    @(posedge core_clk) disable iff (rst)
    clkEn && access && avs_read && avs_address == `UEP_OFF_OUT0_CTL
      |=> rdData[`UEP_BIT_DISABLE] == 1'b0 && rdData[`UEP_BIT_ACTIVE] == 1'b1 && rdData[19:18] == `UEP_KIND_CONTROL;
  endproperty
  a_disZero: assert property (p_disZero) else $error("fixed control bits wrong");
  property p_mpsMirror;
    @(posedge core_clk) disable iff (rst)
    clkEn && access && avs_read && avs_address == `UEP_OFF_OUT0_CTL
      |=> rdData[1:0] == $past(in0Mps);
  endproperty
  a_mpsMirror: assert property (p_mpsMirror) else $error("packet size not mirrored");
  property p_summary;
    @(posedge core_clk) disable iff (rst)
    clkEn && access && avs_read && avs_address == `UEP_OFF_ALL_EVT
      |=> rdData[0] == ($past(inEvt) != 7'h00) && rdData[`UEP_ALL_OUT0] == ($past(out0Evt) != 7'h00);
  endproperty
  a_summary: assert property (p_summary) else $error("summary out of step");
  property p_ownership;
    @(posedge core_clk) disable iff (rst)
    clkEn && inEna && avs_write && access && avs_address == `UEP_OFF_IN_TSIZ && !coreEvt.pktToFifo
      && !coreEvt.pktFromFifo |=> tsiz == $past(tsiz);
  endproperty
  a_ownership: assert property (p_ownership) else $error("size written while enabled");
  property p_fifoReset;
    @(posedge core_clk) $fell(rst) |-> fifoFree == `UEP_FIFO_WORDS;
  endproperty
  a_fifoReset: assert property (p_fifoReset) else $error("fifo space not full after reset");
endmodule
`default_nettype wire

// *** verilog/uep_map.svh ***
// Register offsets, field positions, reset values, field codes and the setup limit of the endpoint control block.
// Assumes inclusion by bare name from the block's design file and testbench.
`ifndef UEP_MAP_SVH
`define UEP_MAP_SVH
`define UEP_OFF_IN_TSIZ 20'h3C930
`define UEP_OFF_IN_DMA 20'h3C934
`define UEP_OFF_IN_FIFO 20'h3C938
`define UEP_OFF_OUT0_CTL 20'h3CB00
`define UEP_OFF_OUT0_EVT 20'h3CB08
`define UEP_OFF_IN_CTL 20'h3C920
`define UEP_OFF_IN_EVT 20'h3C928
`define UEP_OFF_ALL_EVT 20'h3C818
`define UEP_OFF_GLOB_EVT 20'h3C014
`define UEP_OFF_IRQ_MASK 20'h3C018
`define UEP_OFF_IN0_MPS 20'h3C900
`define UEP_FIFO_WORDS 16'h0200
`define UEP_BIT_ENABLE 31
`define UEP_BIT_DISABLE 30
`define UEP_BIT_SNAK 27
`define UEP_BIT_CNAK 26
`define UEP_BIT_STALL 21
`define UEP_BIT_SNOOP 20
`define UEP_BIT_NAKSTS 17
`define UEP_BIT_ACTIVE 15
`define UEP_EV_DONE 0
`define UEP_EV_DISABLED 1
`define UEP_EV_SETUP 3
`define UEP_EV_B2B 6
`define UEP_GLOB_IN 18
`define UEP_GLOB_OUT 19
`define UEP_ALL_OUT0 16
`define UEP_EVT_MASK 32'h0000004F
`define UEP_KIND_CONTROL 2'h0
`define UEP_MAX_SETUP 2'h3
`endif

// *** verilog/uep_pkg.sv ***
// Types shared by the endpoint control block.
// Assumes uep_map.svh supplies the offsets and field positions.
`default_nettype none
package uep_pkg;
  typedef struct packed {
    logic [1:0] perFrame;
    logic [9:0] pktCount;
    logic [18:0] byteCount;
  } uep_tsiz_s;
  typedef struct packed {
    logic pktToFifo;
    logic [18:0] pktBytes;
    logic pktFromFifo;
    logic busBeat;
    logic setupRcvd;
    logic outPktRcvd;
    logic outPktBad;
  } uep_core_s;
  typedef enum logic [1:0] {IDLE, RUN, FINISH} uep_state_e;
endpackage
`default_nettype wire

// *** tb/uep_host_model.sv ***
// Far-side model: protocol engine and bus memory, issuing one-cycle core event pulses.
// Assumes the bench calls its tasks hierarchically; pulses change only after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module uep_host_model
  import uep_pkg::*;
#(
  parameter int BEATS = 16
)
(
  input wire logic core_clk,
  output uep_core_s coreEvt
);
  initial coreEvt = '0;
  task automatic pulse(input uep_core_s v);
    @(posedge core_clk);
    coreEvt <= v;
    @(posedge core_clk);
    coreEvt <= '0;
  endtask
  // A packet is fetched over the bus first, then enters and leaves the FIFO, so bus and USB both finish.
  task automatic in_packet(input logic [18:0] bytes, input int gap);
    uep_core_s v;
    for (int i = 0; i < BEATS; i++) begin
      v = '0;
      v.busBeat = 1'b1;
      pulse(v);
      repeat (gap) @(posedge core_clk);
    end
    v = '0;
    v.pktToFifo = 1'b1;
    v.pktBytes = bytes;
    pulse(v);
    v = '0;
    v.pktFromFifo = 1'b1;
    pulse(v);
  endtask
endmodule
`default_nettype wire

// *** tb/uep_endpoint_ctrl_tb.sv ***
// Self-checking bench of the endpoint control block over its Avalon-MM register port.
// Assumes uep_map.svh on the include path and the far-side model in uep_host_model.sv.
`timescale 1ns/1ps
`include "uep_map.svh"
`default_nettype none
module uep_endpoint_ctrl_tb
  import uep_pkg::*;
;
  logic core_clk = 1'b0, rst = 1'b1, clkEn = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [19:0] avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, rd, endpointMemoryAddress;
  logic [3:0] avs_byteenable = 4'hF;
  logic [1:0] avs_response, lastResp;
  logic [15:0] fifoWordsUsed = 16'h0000;
  logic avs_waitrequest, snoopMode, outNak, inEnabled, setupOverwrite, irq, sawOverwrite = 1'b0;
  uep_core_s coreEvt;
  int miscompares = 0, checks = 0;
  // ---------------------------------------------------------------
  // Clock, design and far side
  // ---------------------------------------------------------------
  initial forever #10 core_clk = ~core_clk;
  uep_endpoint_ctrl dut (.core_clk(core_clk), .rst(rst), .clkEn(clkEn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .coreEvt(coreEvt), .fifoWordsUsed(fifoWordsUsed), .snoopMode(snoopMode), .outNak(outNak),
    .inEnabled(inEnabled), .endpointMemoryAddress(endpointMemoryAddress), .setupOverwrite(setupOverwrite), .irq(irq));
  uep_host_model host (.core_clk(core_clk), .coreEvt(coreEvt));
  always @(posedge core_clk) if (setupOverwrite === 1'b1) sawOverwrite <= 1'b1;
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic close_out();
    $display("Checks %0d, miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // The master holds the request until it samples waitrequest low at a rising edge.
  task automatic bus(input logic [19:0] a, input logic wr, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    lastResp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) begin
      miscompares++;
      $display("ERROR %0t bus wait ran out", $time);
      close_out();
    end
  endtask
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, 4'hF);
  endtask
  task automatic rdx(input logic [19:0] a, input logic [31:0] mask, input logic [31:0] exp, input string what);
    bus(a, 1'b0, '0, 4'hF);
    chk(rd & mask, exp, what);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic fixed_fields();
    rdx(`UEP_OFF_IN_FIFO, 32'hFFFFFFFF, 32'h00000200, "fifo space reset");
    wr(`UEP_OFF_OUT0_CTL, 32'h400C0000);
    wr(`UEP_OFF_IN0_MPS, 32'h00000002);
    rdx(`UEP_OFF_OUT0_CTL, 32'h400C8003, 32'h00008002, "out0 fixed fields");
    wr(`UEP_OFF_IN0_MPS, 32'h00000000);
    rdx(`UEP_OFF_OUT0_CTL, 32'h00000003, 32'h00000000, "out0 packet size 64B");
    @(posedge core_clk) fifoWordsUsed <= 16'h0010;
    rdx(`UEP_OFF_IN_FIFO, 32'hFFFFFFFF, 32'h000001F0, "fifo space used");
    rdx(20'h3C004, 32'hFFFFFFFF, 32'h00000000, "unmapped");
    chk({30'h0, lastResp}, 32'h00000002, "unmapped response");
  endtask
  task automatic in_transfer();
    uep_core_s v;
    int n;
    wr(`UEP_OFF_IN_TSIZ, 32'h20100080);
    wr(`UEP_OFF_IN_DMA, 32'h00001000);
    // A partial write must be refused, or the address check below fails.
    bus(`UEP_OFF_IN_DMA, 1'b1, 32'h0000FFFC, 4'h3);
    wr(`UEP_OFF_IRQ_MASK, 32'h00000001);
    wr(`UEP_OFF_IN_CTL, 32'h80000000);
    wr(`UEP_OFF_IN_TSIZ, 32'h00000004);
    host.in_packet(19'h00040, 0);
    rdx(`UEP_OFF_IN_CTL, 32'h80000000, 32'h80000000, "enabled mid transfer");
    // A beat while the clock enable is low must not move the address.
    v = '0;
    v.busBeat = 1'b1;
    @(posedge core_clk) clkEn <= 1'b0;
    host.pulse(v);
    clkEn <= 1'b1;
    host.in_packet(19'h00040, 1);
    n = 0;
    while (inEnabled !== 1'b0 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 20) begin
      miscompares++;
      $display("ERROR %0t enable never cleared", $time);
      close_out();
    end
    chk({31'h0, irq}, 32'h0, "no event before enable clears");
    chk(endpointMemoryAddress, 32'h00001080, "address after 32 beats");
    repeat (3) @(posedge core_clk);
    chk({31'h0, irq}, 32'h1, "irq on done");
    rdx(`UEP_OFF_IN_TSIZ, 32'hFFFFFFFF, 32'h20000000, "size counters drained");
    rdx(`UEP_OFF_ALL_EVT, 32'h00000001, 32'h00000001, "summary names IN");
    rdx(`UEP_OFF_IN_EVT, 32'h00000001, 32'h00000001, "done flag");
    wr(`UEP_OFF_IN_EVT, 32'h00000001);
    rdx(`UEP_OFF_ALL_EVT, 32'h00000001, 32'h00000000, "summary cleared");
    rdx(`UEP_OFF_GLOB_EVT, 32'h00040000, 32'h00000000, "global cleared");
    chk({31'h0, irq}, 32'h00000000, "irq cleared");
  endtask
  task automatic setup_and_snoop();
    uep_core_s v;
    wr(`UEP_OFF_OUT0_CTL, 32'h80000000);
    chk({31'h0, snoopMode}, 32'h00000000, "snoop off");
    v = '0;
    v.outPktRcvd = 1'b1;
    v.outPktBad = 1'b1;
    host.pulse(v);
    repeat (3) @(posedge core_clk);
    rdx(`UEP_OFF_OUT0_CTL, 32'h80000000, 32'h80000000, "checked bad packet dropped");
    wr(`UEP_OFF_OUT0_CTL, 32'h80100000);
    chk({31'h0, snoopMode}, 32'h00000001, "snoop output");
    v = '0;
    v.setupRcvd = 1'b1;
    repeat (4) host.pulse(v);
    @(posedge core_clk);
    chk({31'h0, sawOverwrite}, 32'h00000001, "fourth setup overwrites");
    chk({31'h0, outNak}, 32'h00000001, "nak after setup");
    rdx(`UEP_OFF_OUT0_EVT, 32'h00000040, 32'h00000040, "back to back setups");
    v = '0;
    v.outPktRcvd = 1'b1;
    v.outPktBad = 1'b1;
    host.pulse(v);
    repeat (3) @(posedge core_clk);
    rdx(`UEP_OFF_OUT0_CTL, 32'h80000000, 32'h00000000, "snooped packet ends");
    rdx(`UEP_OFF_OUT0_EVT, 32'h00000008, 32'h00000008, "setup done after enable clear");
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    fixed_fields();
    in_transfer();
    setup_and_snoop();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    $display("ERROR %0t run limit reached", $time);
    close_out();
  end
endmodule
`default_nettype wire
